// ==== hw/pic_pkg.sv ====
// Purpose: Shared constants and types of the interval counter block.
// Assumes: One 16-bit counter behind an AHB-Lite slave.
// Notes: Offsets are byte addresses of word registers.
package pic_pkg;
  // Register byte offsets.
  localparam logic [7:0] PIC_CTRL_OFS = 8'h00;
  localparam logic [7:0] PIC_COUNT_OFS = 8'h04;
  localparam logic [7:0] PIC_STATUS_OFS = 8'h08;
  // Control word field positions.
  localparam int PIC_MODE_LSB = 0;
  localparam int PIC_BCD_BIT = 3;
  localparam int PIC_ACC_LSB = 4;
  // Status field positions.
  localparam int PIC_STAT_OUT_BIT = 16;
  localparam int PIC_STAT_NULL_BIT = 17;
  localparam int PIC_STAT_RUN_BIT = 18;
  // Byte access formats of the count register.
  localparam logic [1:0] PIC_ACC_LOW = 2'h1;
  localparam logic [1:0] PIC_ACC_HIGH = 2'h2;
  // Reset values.
  localparam logic [1:0] PIC_ACC_RST = 2'h3;
  localparam logic [15:0] PIC_ELEM_RST = 16'h0000;
  localparam logic [15:0] PIC_LATCH_RST = 16'h0000;
  localparam logic PIC_OUT_RST = 1'b1;
  // Tick divider: reference ticks per counter tick and high part.
  localparam logic [3:0] PIC_TICK_DIV = 4'hc;
  localparam logic [3:0] PIC_TICK_HIGH = 4'h6;
  typedef enum logic [2:0] {
    PIC_M0, PIC_M1, PIC_M2, PIC_M3, PIC_M4, PIC_M5
  } pic_mode_e;
  typedef enum logic {PIC_BYTE_LO, PIC_BYTE_HI} pic_byte_e;
endpackage

// ==== hw/pic_sync.sv ====
// Purpose: Two-flop synchroniser with rising edge detect.
// Assumes: Input is asynchronous to hclk.
// Notes: The edge detector reads only the second stage and later.
`timescale 1ns/10ps
`default_nettype none
module pic_sync (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Asynchronous input
  input wire logic async_in,
  // Synchronised outputs
  output logic level,
  output logic rise
);
  logic meta;
  logic last;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta <= 1'b0;
      level <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= async_in;
      level <= meta;
      last <= level;
    end
  end

  assign rise = level & ~last;
endmodule
`default_nettype wire

// ==== hw/pic_tick_div.sv ====
// Purpose: Divides the reference by twelve into counter tick enables.
// Assumes: Reference rises arrive as one-cycle pulses on hclk.
// Notes: Tick edges are enables, never clocks.
`timescale 1ns/10ps
`default_nettype none
module pic_tick_div
  import pic_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Reference edge
  input wire logic ref_rise,
  // Derived tick
  output logic count_tick_clock,
  output logic tick_rise,
  output logic tick_fall
);
  logic [3:0] div;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div <= 4'h0;
      count_tick_clock <= 1'b0;
      tick_rise <= 1'b0;
      tick_fall <= 1'b0;
    end else begin
      tick_rise <= ref_rise && (div == PIC_TICK_DIV - 4'h1);
      tick_fall <= ref_rise && (div == PIC_TICK_HIGH - 4'h1);
      if (ref_rise) begin
        if (div == PIC_TICK_DIV - 4'h1) begin
          div <= 4'h0;
          count_tick_clock <= 1'b1;
        end else begin
          div <= div + 4'h1;
          if (div == PIC_TICK_HIGH - 4'h1) begin
            count_tick_clock <= 1'b0;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== hw/pic_counter.sv ====
// Purpose: One 16-bit interval counter with six modes on AHB-Lite.
// Assumes: Gate and reference are asynchronous pins.
// Notes: Mode 3 duty is computed on binary values of the element.
//
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module pic_counter #(
  parameter int COUNTER_INDEX = 2
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Counter pins
  input wire logic oscillator_input,
  input wire logic count_gate_in,
  output logic count_output
);
  import pic_pkg::*;

  logic dp_wr;
  logic [7:0] dp_addr;
  pic_mode_e mode;
  logic bcd;
  logic [1:0] acc;
  pic_byte_e byte_st;
  logic [15:0] latch;
  logic [15:0] elem;
  logic [15:0] reload_val;
  logic load_pending;
  logic running;
  logic inited;
  logic fired;
  logic trig_ff;
  logic gate_smp;
  logic trig_smp;
  logic gate_lvl;
  logic gate_rise;
  logic ref_rise;
  logic count_tick_clock;
  logic tick_rise;
  logic tick_fall;
  logic gate_eff;
  logic gate_rise_eff;
  logic ap_take;
  logic wr_ctrl;
  logic wr_count;
  logic cnt_done;
  logic lo_only;
  logic do_load;
  logic do_dec;
  logic mode23;
  logic [15:0] next_elem;
  logic [15:0] next_reload;
  logic [16:0] ext_elem;
  logic [16:0] half;
  pic_mode_e wmode;
  logic [7:0] wbyte;

  pic_sync u_gate_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(count_gate_in),
    .level(gate_lvl),
    .rise(gate_rise)
  );

  pic_sync u_ref_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(oscillator_input),
    .level(),
    .rise(ref_rise)
  );

  pic_tick_div u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .ref_rise(ref_rise),
    .count_tick_clock(count_tick_clock),
    .tick_rise(tick_rise),
    .tick_fall(tick_fall)
  );

  assign gate_eff = (COUNTER_INDEX < 2) ? 1'b0 : gate_lvl;
  assign gate_rise_eff = (COUNTER_INDEX < 2) ? 1'b0 : gate_rise;

  // Bus address and data phases.
  assign ap_take = hsel && htrans[1] && hready;
  assign wr_ctrl = dp_wr && (dp_addr == PIC_CTRL_OFS);
  assign wr_count = dp_wr && (dp_addr == PIC_COUNT_OFS);
  assign wbyte = hwdata[7:0];
  // Codes 6 and 7 alias modes 2 and 3 so no illegal mode is stored.
  assign wmode = (hwdata[PIC_MODE_LSB+1 +: 2] == 2'h3) ?
                 pic_mode_e'({1'b0, hwdata[PIC_MODE_LSB +: 2]}) :
                 pic_mode_e'(hwdata[PIC_MODE_LSB +: 3]);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr <= 1'b0;
      dp_addr <= 8'h00;
    end else begin
      dp_wr <= ap_take && hwrite;
      dp_addr <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (ap_take && !hwrite) begin
        if (haddr[7:0] == PIC_CTRL_OFS) begin
          hrdata <= {26'h0000000, acc, bcd, mode};
        end else if (haddr[7:0] == PIC_COUNT_OFS) begin
          hrdata <= {16'h0000, latch};
        end else if (haddr[7:0] == PIC_STATUS_OFS) begin
          hrdata <= {13'h0000, running, load_pending, count_output, elem};
        end else begin
          hrdata <= 32'h00000000;
        end
      end
    end
  end

  // Control word register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode <= PIC_M0;
      bcd <= 1'b0;
      acc <= PIC_ACC_RST;
    end else if (wr_ctrl) begin
      mode <= wmode;
      bcd <= hwdata[PIC_BCD_BIT];
      acc <= hwdata[PIC_ACC_LSB +: 2];
    end
  end

  assign lo_only = wr_count && (acc != PIC_ACC_LOW) && (acc != PIC_ACC_HIGH) &&
                   (byte_st == PIC_BYTE_LO);
  assign cnt_done = wr_count && !lo_only;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latch <= PIC_LATCH_RST;
      byte_st <= PIC_BYTE_LO;
    end else if (wr_ctrl) begin
      byte_st <= PIC_BYTE_LO;
    end else if (wr_count) begin
      if (acc == PIC_ACC_LOW) begin
        latch <= {8'h00, wbyte};
      end else if (acc == PIC_ACC_HIGH) begin
        latch <= {wbyte, 8'h00};
      end else begin
        unique case (byte_st)
          PIC_BYTE_LO: begin
            latch[7:0] <= wbyte;
            byte_st <= PIC_BYTE_HI;
          end
          PIC_BYTE_HI: begin
            latch[15:8] <= wbyte;
            byte_st <= PIC_BYTE_LO;
          end
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_ff <= 1'b0;
    end else if (gate_rise_eff) begin
      trig_ff <= 1'b1;
    end else if (tick_rise) begin
      trig_ff <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gate_smp <= 1'b0;
      trig_smp <= 1'b0;
    end else if (wr_ctrl) begin
      trig_smp <= 1'b0;
    end else if (tick_rise) begin
      gate_smp <= gate_eff;
      trig_smp <= trig_ff || gate_rise_eff;
    end
  end

  function automatic logic [15:0] pic_dec(input logic [15:0] v, input logic dec10);
    logic [15:0] r;
    logic borrow;
    r = v - 16'h0001;
    borrow = 1'b1;
    if (dec10) begin
      for (int i = 0; i < 4; i++) begin
        if (!borrow) begin
          r[i*4 +: 4] = v[i*4 +: 4];
        end else if (v[i*4 +: 4] == 4'h0) begin
          r[i*4 +: 4] = 4'h9;
        end else begin
          r[i*4 +: 4] = v[i*4 +: 4] - 4'h1;
          borrow = 1'b0;
        end
      end
    end
    return r;
  endfunction

  assign mode23 = (mode == PIC_M2) || (mode == PIC_M3);

  always_comb begin
    do_load = 1'b0;
    unique case (mode)
      PIC_M0, PIC_M4: do_load = load_pending;
      PIC_M1, PIC_M5: do_load = trig_smp && inited;
      PIC_M2, PIC_M3: do_load = (trig_smp && inited) || (load_pending && !running) ||
                                (running && gate_smp && (elem == 16'h0001));
    endcase
  end

  assign do_dec = running && !do_load && ((mode == PIC_M1) || gate_smp);
  assign next_elem = do_load ? latch : pic_dec(elem, bcd);
  assign next_reload = do_load ? latch : reload_val;
  assign ext_elem = (next_elem == 16'h0000) ? 17'h10000 : {1'b0, next_elem};
  assign half = {(next_reload == 16'h0000), next_reload} >> 1;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      elem <= PIC_ELEM_RST;
      reload_val <= PIC_ELEM_RST;
    end else if (tick_fall && (do_load || do_dec)) begin
      elem <= next_elem;
      reload_val <= next_reload;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      load_pending <= 1'b0;
      inited <= 1'b0;
    end else if (wr_ctrl) begin
      load_pending <= 1'b0;
      inited <= 1'b0;
    end else begin
      if (tick_fall && do_load) begin
        load_pending <= 1'b0;
      end
      if (lo_only) begin
        load_pending <= 1'b0;
      end
      if (cnt_done) begin
        load_pending <= 1'b1;
        inited <= 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      running <= 1'b0;
      fired <= 1'b0;
    end else if (wr_ctrl) begin
      running <= 1'b0;
      fired <= 1'b0;
    end else if (tick_fall) begin
      if (do_load) begin
        running <= 1'b1;
        fired <= 1'b0;
      end else if (do_dec && (elem == 16'h0001)) begin
        fired <= 1'b1;
      end
    end
  end

  // Output pin; a strobe fires once per load, later wraps stay silent.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_output <= PIC_OUT_RST;
    end else if (wr_ctrl) begin
      count_output <= (wmode != PIC_M0);
    end else if (cnt_done && (mode == PIC_M0)) begin
      count_output <= 1'b0;
    end else if (mode23 && !gate_eff) begin
      count_output <= 1'b1;
    end else if (tick_fall) begin
      unique case (mode)
        PIC_M0: begin
          if (do_dec && (elem == 16'h0001)) begin
            count_output <= 1'b1;
          end
        end
        PIC_M1: begin
          if (do_load) begin
            count_output <= 1'b0;
          end else if (do_dec && (elem == 16'h0001)) begin
            count_output <= 1'b1;
          end
        end
        PIC_M2: begin
          if (do_load || do_dec) begin
            count_output <= do_load || (next_elem != 16'h0001);
          end
        end
        PIC_M3: begin
          if (do_load || do_dec) begin
            count_output <= ext_elem > half;
          end
        end
        PIC_M4, PIC_M5: begin
          count_output <= !(do_dec && !fired && (elem == 16'h0001));
        end
      endcase
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  ctrl_out_low_a: assert property (wr_ctrl && (wmode == PIC_M0) |=> !count_output)
    else $error("Output not low after mode 0 control word.");
  m0_expiry_a: assert property (tick_fall && (mode == PIC_M0) && do_dec && (elem == 16'h0001)
    && !wr_ctrl && !cnt_done |=> count_output && (elem == 16'h0000))
    else $error("Mode 0 output did not rise at zero.");
  gate_hold_a: assert property (tick_fall && (mode == PIC_M0) && !gate_smp && !do_load
    && !wr_ctrl |=> $stable(elem))
    else $error("Element moved with gate low.");
  two_byte_a: assert property (lo_only ##1 (tick_fall && !wr_ctrl && !cnt_done &&
    ((mode == PIC_M0) || (mode == PIC_M4))) |-> !do_load)
    else $error("Load taken before high byte.");
  m2_low_a: assert property (tick_fall && (mode == PIC_M2) && gate_eff && do_dec &&
    (elem == 16'h0002) && !wr_ctrl |=> !count_output)
    else $error("Mode 2 output not low at count one.");
  gate_force_a: assert property (mode23 && !gate_eff && !wr_ctrl |=> count_output)
    else $error("Low gate did not force output high.");
  strobe_one_a: assert property ((mode == PIC_M4) && !count_output && tick_fall && !wr_ctrl
    |=> count_output)
    else $error("Strobe longer than one tick.");
  trig_set_a: assert property (gate_rise_eff |=> trig_ff)
    else $error("Gate rise lost by trigger flag.");
  load_copy_a: assert property (tick_fall && do_load |=> elem == $past(latch))
    else $error("Load did not copy latches.");
  zero_wrap_a: assert property (tick_fall && do_dec && !bcd && (elem == 16'h0000)
    |=> elem == 16'hffff)
    else $error("Element did not wrap to all ones.");
  tick_phase_a: assert property ((tick_fall |-> !count_tick_clock) and (tick_rise |-> count_tick_clock))
    else $error("Tick edge pulse out of phase with divided clock.");

  m0_done_c: cover property (tick_fall && (mode == PIC_M0) && do_dec && (elem == 16'h0001));
  m1_trig_c: cover property ((mode == PIC_M1) && tick_fall && do_load && !count_output);
  m3_fall_c: cover property ((mode == PIC_M3) && $fell(count_output));
  m5_strobe_c: cover property ((mode == PIC_M5) && $fell(count_output));
endmodule
`default_nettype wire

// ==== dv/pic_host.sv ====
// Purpose: Host model that programs the counter over AHB-Lite.
// Assumes: One slave, whose hreadyout is the bus hready.
// Notes: Signals change by non-blocking assignment just after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module pic_host
  import pic_pkg::*;
(
  // Clock
  input wire logic hclk,
  // Bus requests
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  // Bus answers
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // Values are read right after the edge, so they are the ones sampled at it.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic put_count(input logic [15:0] n);
    logic [31:0] rd;
    xfer(1'b1, PIC_COUNT_OFS, {24'h0, n[7:0]}, rd);
    xfer(1'b1, PIC_COUNT_OFS, {24'h0, n[15:8]}, rd);
  endtask
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
// Purpose: Self-checking bench of the interval counter.
// Assumes: Reference toggles every 4 hclk, so one counter tick is 96 hclk.
// Notes: Pulse widths are exact tick multiples; start delays use windows.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import pic_pkg::*;
  localparam int TK = 96;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic oscillator_input, count_gate_in, count_output;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, q;
  int err_total, n_checks, seed, n, t;
  int exp_q[$];

  pic_counter #(.COUNTER_INDEX(2)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .oscillator_input(oscillator_input), .count_gate_in(count_gate_in),
    .count_output(count_output)
  );
  pic_host host (
    .hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata)
  );

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  initial begin
    oscillator_input = 1'b0;
    forever begin
      repeat (4) @(posedge hclk);
      oscillator_input <= ~oscillator_input;
    end
  end

  task automatic end_of_test();
    if (err_total == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] v);
    n_checks++;
    if (v !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", s, e, v);
    end
  endtask
  task automatic win(input string s, input int lo, input int hi);
    chk(s, 32'h1, 32'(t > lo && t <= hi));
  endtask
  task automatic wait_out(input logic v, input int lim, output int c);
    c = 0;
    while (count_output !== v && c < lim) begin
      @(posedge hclk);
      c++;
    end
  endtask
  task automatic rd(input logic [7:0] a);
    host.xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic ctrl(input logic [7:0] w);
    host.xfer(1'b1, PIC_CTRL_OFS, {24'h0, w}, q);
  endtask
  task automatic wave(input int m, input int k);
    int lo;
    int hi;
    ctrl(8'h30 | 8'(m));
    host.put_count(16'(k));
    if (m == 2) begin
      exp_q.push_back(TK);
      exp_q.push_back((k - 1) * TK);
    end else begin
      exp_q.push_back((k / 2) * TK);
      exp_q.push_back(((k + 1) / 2) * TK);
    end
    wait_out(1'b0, 20 * TK, t);
    wait_out(1'b1, 20 * TK, lo);
    wait_out(1'b0, 20 * TK, hi);
    chk("wave_low", exp_q.pop_front(), lo);
    chk("wave_high", exp_q.pop_front(), hi);
  endtask

  initial begin
    repeat (60000) @(posedge hclk);
    err_total++;
    end_of_test();
  end

  initial begin
    hresetn = 1'b0;
    count_gate_in = 1'b0;
    err_total = 0;
    n_checks = 0;
    seed = 32'h5218592c;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    chk("out_rst", 32'h1, count_output);
    rd(PIC_STATUS_OFS);
    chk("status_rst", 32'h00010000, q);
    host.xfer(1'b1, 8'h0c, 32'h0000ffff, q);
    rd(8'h0c);
    chk("unmapped", 32'h0, q);
    chk("hresp", 32'h0, hresp);
    chk("hready", 32'h1, hreadyout);
    n = 5 + ($random(seed) & 3);
    // Mode 0 with the gate high; the low byte alone must not load.
    count_gate_in <= 1'b1;
    ctrl(8'h30);
    repeat (2) @(posedge hclk);
    chk("m0_low", 32'h0, count_output);
    host.xfer(1'b1, PIC_COUNT_OFS, {24'h0, 8'(n)}, q);
    repeat (2 * TK) @(posedge hclk);
    rd(PIC_STATUS_OFS);
    chk("m0_no_load", 32'h0, q[15:0]);
    host.xfer(1'b1, PIC_COUNT_OFS, 32'h0, q);
    wait_out(1'b1, (n + 2) * TK, t);
    win("m0_rise", n * TK, (n + 1) * TK + 8);
    repeat (2 * TK) @(posedge hclk);
    chk("m0_hold", 32'h1, count_output);
    // Mode 0 with the gate low: loads happen, decrements do not.
    count_gate_in <= 1'b0;
    ctrl(8'h30);
    host.put_count(16'h0300 | 16'(n));
    repeat (3 * TK) @(posedge hclk);
    rd(PIC_STATUS_OFS);
    chk("m0_full", 32'h0300 | n, q[15:0]);
    host.put_count(16'(n));
    repeat (2 * TK) @(posedge hclk);
    rd(PIC_STATUS_OFS);
    chk("m0_reload", n, q[15:0]);
    chk("m0_gate_out", 32'h0, count_output);
    count_gate_in <= 1'b1;
    wait_out(1'b1, (n + 2) * TK, t);
    win("m0_gated_rise", (n - 1) * TK, (n + 1) * TK + 8);
    for (int m = 2; m <= 3; m++) begin
      for (int k = 0; k < 2; k++) begin
        wave(m, 4 + 2 * ($random(seed) & 3) + k);
      end
    end
    count_gate_in <= 1'b0;
    wait_out(1'b1, 12, t);
    chk("m3_force", 32'h1, count_output);
    // Mode 4 rewritten mid-sequence.
    count_gate_in <= 1'b1;
    ctrl(8'h34);
    rd(PIC_CTRL_OFS);
    chk("ctrl_rb", 32'h34, q & 32'h3f);
    chk("m4_init", 32'h1, count_output);
    host.put_count(16'(n));
    repeat (2 * TK) @(posedge hclk);
    host.put_count(16'(n));
    wait_out(1'b0, (n + 3) * TK, t);
    win("m4_strobe", n * TK, (n + 1) * TK + 8);
    wait_out(1'b1, 2 * TK, t);
    chk("m4_width", TK, t);
    // Mode 5 waits for a trigger.
    count_gate_in <= 1'b0;
    ctrl(8'h35);
    host.put_count(16'(n));
    repeat ((n + 2) * TK) @(posedge hclk);
    chk("m5_idle", 32'h1, count_output);
    count_gate_in <= 1'b1;
    wait_out(1'b0, (n + 3) * TK, t);
    win("m5_strobe", n * TK, (n + 2) * TK);
    wait_out(1'b1, 2 * TK, t);
    chk("m5_width", TK, t);
    // Mode 1 pulse, then a retrigger that stretches the next one.
    count_gate_in <= 1'b0;
    ctrl(8'h31);
    host.put_count(16'(n));
    repeat (TK) @(posedge hclk);
    count_gate_in <= 1'b1;
    wait_out(1'b0, 3 * TK, t);
    win("m1_start", 0, 2 * TK);
    wait_out(1'b1, (n + 2) * TK, t);
    chk("m1_width", n * TK, t);
    count_gate_in <= 1'b0;
    repeat (TK) @(posedge hclk);
    count_gate_in <= 1'b1;
    wait_out(1'b0, 3 * TK, t);
    repeat (2 * TK) @(posedge hclk);
    count_gate_in <= 1'b0;
    repeat (TK) @(posedge hclk);
    count_gate_in <= 1'b1;
    wait_out(1'b1, (n + 3) * TK, t);
    win("m1_retrig", (n - 1) * TK, (n + 2) * TK);
    end_of_test();
  end
endmodule
`default_nettype wire
